// ==== sim/bas_analog_model.sv ====
// Behavioural analogue front end: channel levels, hold and comparator.
`timescale 1ns/1ps
`default_nettype none
module bas_analog_model (
    input  wire logic        pclk,
    input  wire logic [3:0]  input_route,
    input  wire logic        sample_enable,
    input  wire logic [7:0]  dac_code,
    input  wire logic [31:0] levels,
    output logic             comparator_high
);
    logic [7:0] held = 8'h00;
    // A route that is not one-hot gives a moving value, never a plausible one.
    always @(posedge pclk) begin
        if (sample_enable) begin
            held <= ~held;
            for (int i = 0; i < 4; i++) begin
                if (input_route == (4'h1 << i)) begin
                    held <= levels[8*i +: 8];
                end
            end
        end
    end
    assign comparator_high = (held >= dac_code);
endmodule
`default_nettype wire

// ==== sim/bas_seq_properties.sv ====
// Port-level assertions for the converter sequencer.
`timescale 1ns/1ps
`default_nettype none
module bas_seq_properties #(
    parameter CLK_DIV = 4
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [3:0]  input_route,
    input wire logic        sample_enable,
    input wire logic [7:0]  dac_code,
    input wire logic        conversion_done_irq
);
    logic [15:0] se_cnt;
    logic [15:0] gap;
    logic        mask_on;
    logic        low_ok;
    logic [31:0] low_val;
    wire         done = psel && penable && pready;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            se_cnt <= 16'h0000;
            gap <= 16'hffff;
            mask_on <= 1'b0;
            low_ok <= 1'b0;
            low_val <= 32'h0;
        end else begin
            se_cnt <= sample_enable ? se_cnt + 16'h0001 : 16'h0000;
            if (sample_enable && se_cnt == 16'h0000) begin
                gap <= 16'h0001;
            end else if (gap != 16'hffff) begin
                gap <= gap + 16'h0001;
            end
            if (done && pwrite && paddr == 8'h14) begin
                mask_on <= pwdata[0];
            end
            if (done && !pwrite && paddr == 8'h08) begin
                low_ok <= 1'b0;
            end else if (done && !pwrite && paddr == 8'h04) begin
                low_ok <= 1'b1;
                low_val <= prdata;
            end
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup; psel && !penable; endsequence
    sequence s_wait; psel && penable && !pready; endsequence
    a_one_wait: assert property (s_setup ##1 s_wait |=> pready)
        else $error("pready not in second access cycle");
    a_route_onehot: assert property ($onehot(input_route))
        else $error("route not one-hot");
    a_route_map: assert property (done && pwrite &&
        paddr == 8'h00 |-> ##2 input_route ==
        (4'h1 << {$past(pwdata[0], 2), $past(pwdata[1], 2)}))
        else $error("route does not match select bits");
    a_acq_length: assert property ($fell(sample_enable) |->
        se_cnt == 2 * CLK_DIV) else $error("acquisition length wrong");
    a_trial_start: assert property ($fell(sample_enable) |->
        dac_code == 8'h80) else $error("first trial code wrong");
    a_conv_gap: assert property (sample_enable && se_cnt == 0 |->
        gap >= 10 * CLK_DIV) else $error("conversion cut short");
    a_unmapped_err: assert property (done && paddr > 8'h14 |->
        pslverr && (pwrite || prdata == 32'h0)) else $error("no slave error");
    a_irq_masked: assert property (!mask_on && !$past(mask_on) |->
        !conversion_done_irq) else $error("masked request raised");
    a_low_stable: assert property (done && !pwrite && low_ok
        && paddr == 8'h04 |-> prdata == low_val)
        else $error("low register moved");
endmodule
bind bas_sequencer bas_seq_properties #(.CLK_DIV(CLK_DIV)) bas_seq_properties_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .input_route(input_route),
    .sample_enable(sample_enable), .dac_code(dac_code),
    .conversion_done_irq(conversion_done_irq));
`default_nettype wire

// ==== sim/bipolar_adc_sequencer_tb_top.sv ====
// Self-checking bench for the converter sequencer.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected at %0t got %h exp %h", $time, g, e); end end
module bipolar_adc_sequencer_tb_top;
    localparam int DIV = 4;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cmp;
    logic [3:0]  route;
    logic        refsel;
    logic        se;
    logic [7:0]  dac;
    logic        irq;
    logic [31:0] levels = 32'h0;
    logic        se_d = 1'b0;
    logic [31:0] seed = 32'd74744;
    logic [31:0] r;
    int          bad_count = 0;
    int          checked = 0;
    int          cyc = 0;
    int          rises = 0;
    int          n0;
    int          rise_q[$];
    int          exp_q[$];
    bas_sequencer #(.CLK_DIV(DIV)) bas_sequencer_i (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .comparator_high(cmp), .input_route(route),
        .reference_source_select(refsel), .sample_enable(se),
        .dac_code(dac), .conversion_done_irq(irq));
    bas_analog_model bas_analog_model_i (.pclk(pclk), .input_route(route),
        .sample_enable(se), .dac_code(dac), .levels(levels),
        .comparator_high(cmp));
    initial begin
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        se_d <= se;
        if (se && !se_d) begin
            rises <= rises + 1;
            rise_q.push_back(cyc);
        end
        if (cyc == 4000) begin
            bad_count++;
            finish_test();
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic conv(input int ch, input logic [7:0] v);
        logic [7:0] e;
        int n;
        levels[8*ch +: 8] <= v;
        exp_q.push_back(v);
        apb(1'b1, 8'h10, 32'h1);
        n0 = rises;
        apb(1'b1, 8'h00, {28'h0, 2'b11, ch[0], ch[1]});
        repeat (2) @(posedge pclk);
        `CHK(route, 4'h1 << ch)
        n = 0;
        do begin apb(1'b0, 8'h10, 32'h0); n++; end while (!r[0] && n < 40);
        repeat (12 * DIV) @(posedge pclk);
        `CHK(rises, n0 + 1)
        apb(1'b0, 8'h00, 32'h0);
        `CHK(r[3], 1'b0)
        e = exp_q.pop_front();
        apb(1'b0, 8'h08, 32'h0);
        `CHK(r[3:0], e[7:4])
        apb(1'b0, 8'h04, 32'h0);
        `CHK(r[3:0], e[3:0])
    endtask
    task automatic finish_test;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        `CHK({route, refsel, irq}, 6'h04)
        for (int a = 0; a <= 20; a += 4) begin
            apb(1'b0, a[7:0], 32'h0);
            `CHK(r[3:0], 4'h0)
        end
        apb(1'b0, 8'h40, 32'h0);
        `CHK({pslverr, r}, 33'h100000000)
        apb(1'b1, 8'h0c, 32'h8);
        @(posedge pclk);
        `CHK(refsel, 1'b1)
        $display("reset and register test done");
        for (int ch = 0; ch < 4; ch++) begin
            seed = xs(seed);
            conv(ch, ch == 0 ? seed[7:0] : 8'hff << (ch * 4 - 4));
        end
        apb(1'b0, 8'h04, 32'h0);
        `CHK(r[3:0], 4'h0)
        `CHK(irq, 1'b0)
        apb(1'b1, 8'h14, 32'h1);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b1)
        apb(1'b1, 8'h10, 32'h1);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b0)
        $display("single mode test done");
        seed = xs(seed);
        levels[23:16] <= seed[7:0];
        n0 = rises;
        apb(1'b1, 8'h00, 32'h9);
        for (int k = 0; k < 400 && rises < n0 + 3; k++) @(posedge pclk);
        `CHK(rise_q[$] - rise_q[$-1], 10 * DIV)
        apb(1'b0, 8'h08, 32'h0);
        `CHK(r[3:0], seed[7:4])
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b0, 8'h00, 32'h0);
        `CHK(r[3], 1'b1)
        repeat (2) @(posedge pclk);
        n0 = rises;
        repeat (15 * DIV) @(posedge pclk);
        `CHK(rises, n0)
        apb(1'b0, 8'h00, 32'h0);
        `CHK(r[3], 1'b0)
        $display("continuous mode test done");
        finish_test();
    end
endmodule
`default_nettype wire

// ==== src/bas_defs.vh ====
// Constants for the bipolar converter sequencer: offsets, fields, timing.
//
// Behaviour
// - One input reaches the converter via the mux; reference after reset.
// - Select pair A,B: 00 reference, 01 B, 10 A, 11 virtual ground.
// - Two acquisition cycles start a conversion; sample held to its end.
// - A conversion, acquisition included, lasts ten clock cycles.
// - On data valid, upper four bits go to high register, lower to shadow.
// - Only a high register read copies the shadow into the low register.
// - Result bit 7 is the sign: one above virtual ground, zero below.
// - Negative side in ones complement; -full reads 0x00, +full reads 0xff.
// - Reference select 1: internal supply; 0, the reset value: the pad.
// - Mode bit 0 means continuous operation, 1 means single conversion.
// - After reset mode, start and both select bits are zero.
// - In continuous mode, start repeats conversions at about 3.2 kHz.
// - Clearing start in continuous mode ends after the current conversion.
// - Each completed conversion raises the request, in both modes.
// - The interrupt request has its own mask bit, masked after reset.
// - In single mode start triggers exactly one conversion, then idle.
// - Single mode clears start at conversion end, raising the request then.
`ifndef BAS_DEFS_VH
`define BAS_DEFS_VH

`define BAS_OFS_CONTROL 8'h00
`define BAS_OFS_LOW     8'h04
`define BAS_OFS_HIGH    8'h08
`define BAS_OFS_SYSCTL3 8'h0c
`define BAS_OFS_STATUS  8'h10
`define BAS_OFS_MASK    8'h14

`define BAS_CTL_SEL_A  0
`define BAS_CTL_SEL_B  1
`define BAS_CTL_SINGLE 2
`define BAS_CTL_GO     3
`define BAS_SYS_REFSEL 3
`define BAS_IRQ_DONE   0

`define BAS_PCLK_HZ     20000000
`define BAS_REPEAT_HZ   3200
`define BAS_CONV_CYCLES 10
`define BAS_ACQ_CYCLES  2
`define BAS_CLK_DIV     (`BAS_PCLK_HZ / (`BAS_REPEAT_HZ * `BAS_CONV_CYCLES))

`endif

// ==== src/bas_sequencer.v ====
// Sequencer for an 8-bit bipolar successive-approximation converter.
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "bas_defs.vh"

module bas_sequencer #(
    parameter CLK_DIV = `BAS_CLK_DIV
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        comparator_high,
    output reg  [3:0]  input_route,
    output reg         reference_source_select,
    output reg         sample_enable,
    output reg  [7:0]  dac_code,
    output reg         conversion_done_irq
);

    localparam ST_IDLE = 2'd0;
    localparam ST_ACQ  = 2'd1;
    localparam ST_CONV = 2'd2;

    reg  [15:0] div_count;
    reg         tick;
    reg  [1:0]  state;
    reg  [2:0]  step;
    reg         input_select_a;
    reg         input_select_b;
    reg         single_mode;
    reg         conversion_go;
    reg  [3:0]  result_high_reg;
    reg  [3:0]  result_low_reg;
    reg  [3:0]  shadow_low;
    reg         irq_status;
    reg         conversion_irq_mask;
    reg  [7:0]  conversion_result;
    reg  [31:0] next_rdata;
    reg         next_err;
    reg         done_set;
    wire        access;
    wire        first;
    wire        wr;
    wire        rd;

    assign first  = psel & penable & ~pready;
    assign access = psel & penable & pready;
    assign wr     = access & pwrite;
    assign rd     = access & ~pwrite;

    // One-cycle enable at the converter clock rate.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_count <= 16'h0000;
            tick      <= 1'b0;
        end else if (div_count == CLK_DIV[15:0] - 16'h0001) begin
            div_count <= 16'h0000;
            tick      <= 1'b1;
        end else begin
            div_count <= div_count + 16'h0001;
            tick      <= 1'b0;
        end
    end

    // Bus answer is registered: pready rises on the second access cycle.
    always @* begin
        next_rdata = 32'h0000_0000;
        next_err   = 1'b0;
        if (paddr == `BAS_OFS_CONTROL) begin
            next_rdata[`BAS_CTL_GO]     = (state != ST_IDLE);
            next_rdata[`BAS_CTL_SINGLE] = single_mode;
            next_rdata[`BAS_CTL_SEL_B]  = input_select_b;
            next_rdata[`BAS_CTL_SEL_A]  = input_select_a;
        end else if (paddr == `BAS_OFS_LOW) begin
            next_rdata[3:0] = result_low_reg;
        end else if (paddr == `BAS_OFS_HIGH) begin
            next_rdata[3:0] = result_high_reg;
        end else if (paddr == `BAS_OFS_SYSCTL3) begin
            next_rdata[`BAS_SYS_REFSEL] = reference_source_select;
        end else if (paddr == `BAS_OFS_STATUS) begin
            next_rdata[`BAS_IRQ_DONE] = irq_status;
        end else if (paddr == `BAS_OFS_MASK) begin
            next_rdata[`BAS_IRQ_DONE] = conversion_irq_mask;
        end else begin
            next_err = 1'b1;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= first;
            pslverr <= first & next_err;
            if (first & ~pwrite) begin
                prdata <= next_rdata;
            end else if (access) begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // Software-owned configuration bits.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_select_a          <= 1'b0;
            input_select_b          <= 1'b0;
            single_mode             <= 1'b0;
            reference_source_select <= 1'b0;
            conversion_irq_mask     <= 1'b0;
        end else if (wr && paddr == `BAS_OFS_CONTROL) begin
            input_select_a <= pwdata[`BAS_CTL_SEL_A];
            input_select_b <= pwdata[`BAS_CTL_SEL_B];
            single_mode    <= pwdata[`BAS_CTL_SINGLE];
        end else if (wr && paddr == `BAS_OFS_SYSCTL3) begin
            reference_source_select <= pwdata[`BAS_SYS_REFSEL];
        end else if (wr && paddr == `BAS_OFS_MASK) begin
            conversion_irq_mask <= pwdata[`BAS_IRQ_DONE];
        end
    end

    // One-hot mux drive: bit 0 reference, 1 B input, 2 A input, 3 ground.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_route <= 4'h1;
        end else begin
            input_route <= 4'h1 << {input_select_a, input_select_b};
        end
    end

    // Start bit: software sets or clears it; single mode clears it at
    // the end of its conversion unless software writes in that cycle.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conversion_go <= 1'b0;
        end else if (wr && paddr == `BAS_OFS_CONTROL) begin
            conversion_go <= pwdata[`BAS_CTL_GO];
        end else if (done_set && single_mode) begin
            conversion_go <= 1'b0;
        end
    end

    always @* begin
        done_set = tick && state == ST_CONV && step == 3'd0;
    end

    // Two acquisition cycles then eight bit decisions, msb first.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state             <= ST_IDLE;
            step              <= 3'd0;
            sample_enable     <= 1'b0;
            conversion_result <= 8'h00;
            dac_code          <= 8'h00;
        end else if (tick) begin
            case (state)
                ST_IDLE: begin
                    if (conversion_go) begin
                        state         <= ST_ACQ;
                        step          <= 3'd0;
                        sample_enable <= 1'b1;
                    end
                end
                ST_ACQ: begin
                    if (step == `BAS_ACQ_CYCLES - 1) begin
                        state         <= ST_CONV;
                        step          <= 3'd7;
                        sample_enable <= 1'b0;
                        dac_code      <= 8'h80;
                    end else begin
                        step <= step + 3'd1;
                    end
                end
                ST_CONV: begin
                    // Code is monotonic: 0x80 is ground, ones complement
                    // below it, so the plain search yields the bipolar form.
                    conversion_result[step] <= comparator_high;
                    if (step != 3'd0) begin
                        dac_code[step]        <= comparator_high;
                        dac_code[step - 3'd1] <= 1'b1;
                        step                  <= step - 3'd1;
                    end else begin
                        dac_code[0] <= comparator_high;
                        step        <= 3'd0;
                        if (conversion_go && !single_mode) begin
                            state         <= ST_ACQ;
                            sample_enable <= 1'b1;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Result capture on data valid, and copy-out on a high read.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_high_reg <= 4'h0;
            shadow_low      <= 4'h0;
            result_low_reg  <= 4'h0;
        end else begin
            if (done_set) begin
                // Bit 0 is decided at this very tick, so it comes straight
                // from the comparator rather than from the result register.
                result_high_reg <= conversion_result[7:4];
                shadow_low      <= {conversion_result[3:1],
                                    comparator_high};
            end
            if (rd && paddr == `BAS_OFS_HIGH) begin
                result_low_reg <= shadow_low;
            end
        end
    end

    // Sticky done flag, write one to clear, set wins over clear.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status          <= 1'b0;
            conversion_done_irq <= 1'b0;
        end else begin
            if (done_set) begin
                irq_status <= 1'b1;
            end else if (wr && paddr == `BAS_OFS_STATUS &&
                         pwdata[`BAS_IRQ_DONE]) begin
                irq_status <= 1'b0;
            end
            conversion_done_irq <= irq_status & conversion_irq_mask;
        end
    end

endmodule

`default_nettype wire

// ==== src/placeholder_none.v ====
// Intentionally empty source unit kept out of the design.
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire
